// [sdhts_card_model.sv]
// behavioural sd card that answers every host frame with an echo reply
// assumes the host drives after sd clock falls and samples after rises
`timescale 1ns/1ps
module sdhts_card_model (
  input  wire logic       en,
  input  wire logic       hostOe,
  input  wire logic       hostBit,
  input  wire logic [5:0] failIdx,
  output logic            sdClk,
  output logic            cardOe,
  output logic            cardBit,
  output logic [47:0]     lastFrame,
  output logic [47:0]     prevFrame,
  output int              frames
);
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int k = 39; k >= 0; k--) begin
      c = {c[5:0], 1'b0} ^ ((d[k] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  // clock stands still while en is low; the bench drops it only between scenarios
  initial begin
    sdClk = 1'b0;
    forever begin
      if (en) begin
        #160 sdClk = 1'b1;
        #160 sdClk = 1'b0;
      end else begin
        #40;
      end
    end
  end
  // a bad crc is the only fault, sent for the index in failIdx
  initial begin
    logic [47:0] f;
    logic [47:0] rsp;
    cardOe = 1'b0;
    cardBit = 1'b1;
    lastFrame = 48'h0;
    prevFrame = 48'h0;
    frames = 0;
    forever begin
      @(posedge sdClk iff (hostOe && !hostBit));
      f = 48'h0;
      for (int i = 0; i < 48; i++) begin
        if (i > 0) @(posedge sdClk);
        f = {f[46:0], hostBit};
      end
      prevFrame = lastFrame;
      lastFrame = f;
      frames++;
      rsp[47:8] = {2'b00, f[45:8]};
      rsp[7:1] = crc7(rsp[47:8]) ^ {6'h00, f[45:40] == failIdx};
      rsp[0] = 1'b1;
      repeat (2) @(negedge sdClk);
      for (int i = 0; i < 48; i++) begin
        cardOe = 1'b1;
        cardBit = rsp[47-i];
        @(negedge sdClk);
      end
      cardOe = 1'b0;
      cardBit = 1'b1;
    end
  end
endmodule // sdhts_card_model

// [sdhts_checker.sv]
// concurrent checks on the ports of the sd host transfer setup block
// assumes one mclk domain and a bench sd clock of eight mclk periods
`timescale 1ns/1ps
module sdhts_checker (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        cmdOut,
  input wire logic        cmdOe,
  input wire logic        blockDone,
  input wire logic        xferActive
);
  // ****************************************************************
  // helpers and sequences
  // ****************************************************************
  logic wrAddr;
  logic rdAddr;
  assign wrAddr = hsel && htrans[1] && hready && hwrite;
  assign rdAddr = hsel && htrans[1] && hready && !hwrite;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_start;
    $rose(cmdOe) ##0 !cmdOut;
  endsequence
  sequence s_txbit;
    ##12 cmdOut;
  endsequence
  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_FRAME_START: assert property ($rose(cmdOe) |-> s_start)
    else $error("frame did not open with a start bit of zero");
  AST_OE_HOLD: assert property (s_start |=> cmdOe [*8])
    else $error("cmd drive dropped inside the first bit");
  AST_TX_BIT: assert property (s_start |-> s_txbit)
    else $error("transmission bit of host frame not one");
  AST_END_BIT: assert property ($fell(cmdOe) |-> $past(cmdOut))
    else $error("frame released without an end bit of one");
  AST_IDLE: assert property (!cmdOe |-> cmdOut)
    else $error("cmd output not high while released");
  // a bit stands a whole sd clock period, sync jitter costs one cycle
  AST_BIT_HOLD: assert property (
    cmdOe && $changed(cmdOut) |=> $stable(cmdOut) [*6])
    else $error("cmd bit changed early");
  AST_ACT_END: assert property (
    $fell(xferActive) |-> $past(blockDone) || $past(srst)
      || $past(wrAddr, 2) || $past(wrAddr, 3))
    else $error("data phase ended with no block done or abort");
  AST_NO_TX_DATA: assert property (xferActive |-> !cmdOe)
    else $error("command sent during data phase");
  AST_STRAY_BLOCK: assert property (
    blockDone && !xferActive |=> !xferActive)
    else $error("block done outside transfer started data");
  AST_RD_STANDS: assert property (!rdAddr |=> $stable(hrdata))
    else $error("read data changed without a read");
  AST_RESET: assert property (
    $fell(srst) |-> cmdOut && !cmdOe && !xferActive && hrdata == 32'h0)
    else $error("outputs not at reset values");
endmodule // sdhts_checker

// [sdhts_cmd_link.sv]
// command line engine: sends one 48-bit frame and takes the 48-bit answer
// assumes sdClk and cmdIn come from outside the mclk domain
`timescale 1ns/1ps
module sdhts_cmd_link #(
  parameter int RSP_TIMEOUT = sdhts_pkg::RSP_TIMEOUT_CLKS
) (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               sdClk,
  input  wire logic               cmdIn,
  input  wire logic               sendReq,
  input  wire sdhts_pkg::sdhts_cmd_s sendCmd,
  output logic                    cmdOut,
  output logic                    cmdOe,
  output logic                    rspDone,
  output logic                    rspErr,
  output logic [31:0]             rspArg
);

  typedef enum {L_IDLE, L_TX, L_WAIT, L_RX} sdhts_link_e;

  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ 7'h09;
      end
    end
    return c;
  endfunction

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  logic clkS1_q, clkS2_q, clkS3_q, cmdS1_q, cmdS2_q;
  logic sdRise, sdFall;

  always_ff @(posedge mclk) begin
    clkS1_q <= sdClk;
    clkS2_q <= clkS1_q;
    clkS3_q <= clkS2_q;
    cmdS1_q <= cmdIn;
    cmdS2_q <= cmdS1_q;
  end

  assign sdRise = clkS2_q & ~clkS3_q;
  assign sdFall = ~clkS2_q & clkS3_q;

  // ****************************************************************
  // frame shifter
  // ****************************************************************
  sdhts_link_e st_q, st_d;
  logic [47:0] sh_q, sh_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [5:0]  idx_q, idx_d;
  logic        out_q, out_d, oe_q, oe_d, done_q, done_d, err_q, err_d;
  logic [31:0] arg_q, arg_d;

  always_comb begin
    logic [47:0] rx;
    rx     = {sh_q[46:0], cmdS2_q};
    st_d   = st_q;
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    idx_d  = idx_q;
    out_d  = out_q;
    oe_d   = oe_q;
    done_d = 1'b0;
    err_d  = err_q;
    arg_d  = arg_q;
    case (st_q)
      L_IDLE: begin
        if (sendReq) begin
          sh_d  = {2'b01, sendCmd.idx, sendCmd.arg,
                   crc7({2'b01, sendCmd.idx, sendCmd.arg}), 1'b1};
          idx_d = sendCmd.idx;
          cnt_d = 8'(sdhts_pkg::FRAME_W);
          st_d  = L_TX;
        end
      end
      L_TX: begin
        // drive after the falling edge so the card sees it stable on rise
        if (sdFall) begin
          if (cnt_q == 8'h00) begin
            oe_d  = 1'b0;
            out_d = 1'b1;
            st_d  = L_WAIT;
          end else begin
            oe_d  = 1'b1;
            out_d = sh_q[47];
            sh_d  = {sh_q[46:0], 1'b1};
            cnt_d = cnt_q - 8'h01;
          end
        end
      end
      L_WAIT: begin
        if (sdRise) begin
          if (!cmdS2_q) begin
            sh_d  = '0;
            cnt_d = 8'(sdhts_pkg::FRAME_W - 1);
            st_d  = L_RX;
          end else if (cnt_q == 8'(RSP_TIMEOUT - 1)) begin
            done_d = 1'b1;
            err_d  = 1'b1;
            st_d   = L_IDLE;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
      end
      L_RX: begin
        if (sdRise) begin
          sh_d  = rx;
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            done_d = 1'b1;
            arg_d  = rx[39:8];
            err_d  = rx[46] | (rx[45:40] != idx_q) | ~rx[0] |
                     (rx[7:1] != crc7(rx[47:8]));
            st_d   = L_IDLE;
          end
        end
      end
      default: st_d = L_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q   <= L_IDLE;
      sh_q   <= '0;
      cnt_q  <= 8'h00;
      idx_q  <= 6'h00;
      out_q  <= 1'b1;
      oe_q   <= 1'b0;
      done_q <= 1'b0;
      err_q  <= 1'b0;
      arg_q  <= sdhts_pkg::WORD_RST;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      idx_q  <= idx_d;
      out_q  <= out_d;
      oe_q   <= oe_d;
      done_q <= done_d;
      err_q  <= err_d;
      arg_q  <= arg_d;
    end
  end

  assign cmdOut  = out_q;
  assign cmdOe   = oe_q;
  assign rspDone = done_q;
  assign rspErr  = err_q;
  assign rspArg  = arg_q;

endmodule // sdhts_cmd_link

// [sdhts_pkg.sv]
// constants, field layouts and carriers for the sd host transfer setup block
// assumes a 32-bit ahb-lite register bus and one sd command line
package sdhts_pkg;

  // ****************************************************************
  // register map: index as printed, byte address is four times it
  // ****************************************************************
  localparam int         ADDR_W        = 8;
  localparam logic [5:0] SDMA_IDX      = 6'h00;
  localparam logic [5:0] BLK_CNT_IDX   = 6'h06;
  localparam logic [5:0] ARG_IDX       = 6'h08;
  localparam logic [5:0] XFER_MODE_IDX = 6'h0C;
  localparam logic [5:0] CMD_REG_IDX   = 6'h0E;
  localparam logic [5:0] AUTO_ERR_IDX  = 6'h0F;
  localparam logic [5:0] STATUS_IDX    = 6'h10;
  localparam logic [5:0] RESP_IDX      = 6'h11;

  // ****************************************************************
  // field positions and codes
  // ****************************************************************
  localparam int        CMD_IDX_LO   = 8;
  localparam int        CMD_DATA_BIT = 5;
  localparam logic [1:0] AUTO_NONE   = 2'h0;
  localparam logic [1:0] AUTO_12     = 2'h1;
  localparam logic [1:0] AUTO_23     = 2'h2;
  localparam logic [5:0] CMD12_IDX   = 6'h0C;
  localparam logic [5:0] CMD23_IDX   = 6'h17;
  localparam logic [2:0] HSIZE_WORD  = 3'h2;
  localparam int        AERR_CMD12   = 0;
  localparam int        AERR_CMD23   = 1;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [15:0] BLK_CNT_RST = 16'h0000;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam int          FRAME_W     = 48;
  localparam int          RSP_TIMEOUT_CLKS = 64;

  typedef struct packed {
    logic [5:0]  idx;
    logic [31:0] arg;
  } sdhts_cmd_s;

  typedef struct packed {
    logic       multi;
    logic       dirRead;
    logic [1:0] autoCmd;
    logic       cntEn;
    logic       dmaEn;
  } sdhts_mode_s;

endpackage

// [sdhts_transfer_setup.sv]
// transfer setup registers and command sequencer of an sd host controller
// assumes a single ahb-lite master and a data path that pulses blockDone
`timescale 1ns/1ps
module sdhts_transfer_setup #(
  parameter int ADDR_W      = sdhts_pkg::ADDR_W,
  parameter int RSP_TIMEOUT = sdhts_pkg::RSP_TIMEOUT_CLKS
) (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              sdClk,
  input  wire logic              cmdIn,
  output logic                   cmdOut,
  output logic                   cmdOe,
  input  wire logic              blockDone,
  output logic                   xferActive,
  output logic                   xferRead,
  output logic                   xferDma
);

  typedef enum {M_IDLE, M_A23, M_MAIN, M_DATA, M_A12} sdhts_seq_e;

  function automatic logic [ADDR_W-1:0] byteAddr(input logic [5:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction

  // ****************************************************************
  // ahb-lite slave, zero wait states
  // ****************************************************************
  logic              wrPend_q, wrPend_d;
  logic [ADDR_W-1:0] wrAddr_q, wrAddr_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              apValid;
  logic [31:0]       readMux;

  sdhts_seq_e            st_q, st_d;
  logic [15:0]           blkCnt_q, blkCnt_d;
  logic [31:0]           arg_q, arg_d, sdma_q, sdma_d;
  sdhts_pkg::sdhts_mode_s mode_q, mode_d;
  logic [5:0]            cmdIdx_q, cmdIdx_d;
  logic                  dataPres_q, dataPres_d;
  logic [1:0]            autoErr_q, autoErr_d;
  logic                  mainErr_q, mainErr_d;
  logic                  sendReq_q, sendReq_d;
  sdhts_pkg::sdhts_cmd_s sendCmd_q, sendCmd_d;
  logic                  rspDone, rspErr;
  logic [31:0]           rspArg;

  assign apValid = hsel & htrans[1] & hready;

  always_comb begin
    readMux = 32'h0000_0000;
    if (haddr == byteAddr(sdhts_pkg::BLK_CNT_IDX)) begin
      readMux = {16'h0000, blkCnt_q};
    end else if (haddr == byteAddr(sdhts_pkg::ARG_IDX)) begin
      readMux = arg_q;
    end else if (haddr == byteAddr(sdhts_pkg::XFER_MODE_IDX)) begin
      readMux = {26'h0, mode_q};
    end else if (haddr == byteAddr(sdhts_pkg::CMD_REG_IDX)) begin
      readMux = {18'h0, cmdIdx_q, 2'b00, dataPres_q, 5'h00};
    end else if (haddr == byteAddr(sdhts_pkg::SDMA_IDX)) begin
      readMux = sdma_q;
    end else if (haddr == byteAddr(sdhts_pkg::AUTO_ERR_IDX)) begin
      readMux = {30'h0, autoErr_q};
    end else if (haddr == byteAddr(sdhts_pkg::STATUS_IDX)) begin
      readMux = {29'h0, mainErr_q, (st_q == M_DATA), (st_q != M_IDLE)};
    end else if (haddr == byteAddr(sdhts_pkg::RESP_IDX)) begin
      readMux = rspArg;
    end
  end

  always_comb begin
    wrPend_d = apValid & hwrite & (hsize == sdhts_pkg::HSIZE_WORD);
    wrAddr_d = apValid ? haddr : wrAddr_q;
    // read data is caught in the address phase so hrdata is a flop
    rdata_d  = (apValid & ~hwrite) ? readMux : rdata_q;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
      rdata_q  <= sdhts_pkg::WORD_RST;
    end else begin
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      rdata_q  <= rdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // ****************************************************************
  // registers and command sequencer
  // ****************************************************************
  always_comb begin
    logic wrHit[8];
    logic cmdWr, countOn, lastBlk;
    for (int i = 0; i < 8; i++) begin
      wrHit[i] = 1'b0;
    end
    wrHit[0] = wrPend_q & (wrAddr_q == byteAddr(sdhts_pkg::BLK_CNT_IDX));
    wrHit[1] = wrPend_q & (wrAddr_q == byteAddr(sdhts_pkg::ARG_IDX));
    wrHit[2] = wrPend_q & (wrAddr_q == byteAddr(sdhts_pkg::XFER_MODE_IDX));
    wrHit[3] = wrPend_q & (wrAddr_q == byteAddr(sdhts_pkg::SDMA_IDX));
    wrHit[4] = wrPend_q & (wrAddr_q == byteAddr(sdhts_pkg::AUTO_ERR_IDX));
    cmdWr    = wrPend_q & (wrAddr_q == byteAddr(sdhts_pkg::CMD_REG_IDX));
    countOn  = mode_q.multi & mode_q.cntEn;
    lastBlk  = ~mode_q.multi | (countOn & (blkCnt_q == 16'h0001));

    st_d       = st_q;
    blkCnt_d   = blkCnt_q;
    arg_d      = wrHit[1] ? hwdata : arg_q;
    mode_d     = wrHit[2] ? hwdata[5:0] : mode_q;
    sdma_d     = wrHit[3] ? hwdata : sdma_q;
    cmdIdx_d   = cmdIdx_q;
    dataPres_d = dataPres_q;
    mainErr_d  = mainErr_q;
    sendReq_d  = 1'b0;
    sendCmd_d  = sendCmd_q;
    // write one to clear; a flag raised below in the same cycle wins
    autoErr_d  = wrHit[4] ? (autoErr_q & ~hwdata[1:0]) : autoErr_q;

    if ((st_q == M_DATA) && blockDone && countOn &&
        (blkCnt_q != 16'h0000)) begin
      blkCnt_d = blkCnt_q - 16'h0001;
    end
    if (wrHit[0]) begin
      blkCnt_d = hwdata[15:0];
    end

    case (st_q)
      M_IDLE: begin
        if (cmdWr) begin
          cmdIdx_d   = hwdata[sdhts_pkg::CMD_IDX_LO +: 6];
          dataPres_d = hwdata[sdhts_pkg::CMD_DATA_BIT];
          mainErr_d  = 1'b0;
          sendReq_d  = 1'b1;
          // the sequence does not look at the dma setting
          if (mode_q.autoCmd == sdhts_pkg::AUTO_23) begin
            sendCmd_d = '{idx: sdhts_pkg::CMD23_IDX, arg: sdma_q};
            st_d      = M_A23;
          end else begin
            sendCmd_d = '{idx: hwdata[sdhts_pkg::CMD_IDX_LO +: 6],
                          arg: arg_q};
            st_d      = M_MAIN;
          end
        end
      end
      M_A23: begin
        if (rspDone) begin
          if (rspErr) begin
            autoErr_d[sdhts_pkg::AERR_CMD23] = 1'b1;
            st_d = M_IDLE;
          end else begin
            sendReq_d = 1'b1;
            sendCmd_d = '{idx: cmdIdx_q, arg: arg_q};
            st_d      = M_MAIN;
          end
        end
      end
      M_MAIN: begin
        if (rspDone) begin
          if (rspErr) begin
            mainErr_d = 1'b1;
            st_d      = M_IDLE;
          end else if (!dataPres_q) begin
            st_d = M_IDLE;
          end else if (countOn && (blkCnt_q == 16'h0000)) begin
            st_d = M_IDLE;
          end else begin
            st_d = M_DATA;
          end
        end
      end
      M_DATA: begin
        // endless transfers end only by a command register write
        if (cmdWr) begin
          st_d = M_IDLE;
        end else if (blockDone && lastBlk) begin
          if (mode_q.multi && mode_q.autoCmd == sdhts_pkg::AUTO_12) begin
            sendReq_d = 1'b1;
            sendCmd_d = '{idx: sdhts_pkg::CMD12_IDX, arg: 32'h0000_0000};
            st_d      = M_A12;
          end else begin
            st_d = M_IDLE;
          end
        end
      end
      M_A12: begin
        if (rspDone) begin
          if (rspErr) begin
            autoErr_d[sdhts_pkg::AERR_CMD12] = 1'b1;
          end
          st_d = M_IDLE;
        end
      end
      default: st_d = M_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q       <= M_IDLE;
      blkCnt_q   <= sdhts_pkg::BLK_CNT_RST;
      arg_q      <= sdhts_pkg::WORD_RST;
      mode_q     <= '0;
      sdma_q     <= sdhts_pkg::WORD_RST;
      cmdIdx_q   <= 6'h00;
      dataPres_q <= 1'b0;
      autoErr_q  <= 2'h0;
      mainErr_q  <= 1'b0;
      sendReq_q  <= 1'b0;
      sendCmd_q  <= '0;
    end else begin
      st_q       <= st_d;
      blkCnt_q   <= blkCnt_d;
      arg_q      <= arg_d;
      mode_q     <= mode_d;
      sdma_q     <= sdma_d;
      cmdIdx_q   <= cmdIdx_d;
      dataPres_q <= dataPres_d;
      autoErr_q  <= autoErr_d;
      mainErr_q  <= mainErr_d;
      sendReq_q  <= sendReq_d;
      sendCmd_q  <= sendCmd_d;
    end
  end

  assign xferActive = (st_q == M_DATA);
  assign xferRead   = mode_q.dirRead;
  assign xferDma    = mode_q.dmaEn;

  // ****************************************************************
  // command line
  // ****************************************************************
  sdhts_cmd_link #(
    .RSP_TIMEOUT (RSP_TIMEOUT)
  ) u_link (
    .mclk    (mclk),
    .srst    (srst),
    .sdClk   (sdClk),
    .cmdIn   (cmdIn),
    .sendReq (sendReq_q),
    .sendCmd (sendCmd_q),
    .cmdOut  (cmdOut),
    .cmdOe   (cmdOe),
    .rspDone (rspDone),
    .rspErr  (rspErr),
    .rspArg  (rspArg)
  );

endmodule // sdhts_transfer_setup

// [tb.sv]
// self-checking bench: ahb-lite master tasks and one task per scenario
// assumes the card model on the cmd line, pulled up when nobody drives
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] A_SDMA = {sdhts_pkg::SDMA_IDX, 2'b00};
  localparam logic [7:0] A_BLK  = {sdhts_pkg::BLK_CNT_IDX, 2'b00};
  localparam logic [7:0] A_ARG  = {sdhts_pkg::ARG_IDX, 2'b00};
  localparam logic [7:0] A_MODE = {sdhts_pkg::XFER_MODE_IDX, 2'b00};
  localparam logic [7:0] A_CMD  = {sdhts_pkg::CMD_REG_IDX, 2'b00};
  localparam logic [7:0] A_AERR = {sdhts_pkg::AUTO_ERR_IDX, 2'b00};
  localparam logic [7:0] A_STAT = {sdhts_pkg::STATUS_IDX, 2'b00};
  logic        mclk, srst, hsel, hwrite, blockDone, clkEn;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [5:0]  failIdx;
  wire  [31:0] hrdata;
  wire  [47:0] lastFrame, prevFrame;
  wire         hreadyout, hresp, sdClk, cmdOut, cmdOe, cardOe, cardBit;
  wire         xferActive, xferRead, xferDma, cmdIn;
  int          frames, fails, checks_done;
  assign cmdIn = cmdOe ? cmdOut : (cardOe ? cardBit : 1'b1);
  sdhts_transfer_setup #(.RSP_TIMEOUT(8)) u_sdhts_transfer_setup (
    .mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sdClk(sdClk),
    .cmdIn(cmdIn), .cmdOut(cmdOut), .cmdOe(cmdOe), .blockDone(blockDone),
    .xferActive(xferActive), .xferRead(xferRead), .xferDma(xferDma));
  sdhts_card_model u_sdhts_card_model (.en(clkEn), .hostOe(cmdOe),
    .hostBit(cmdIn), .failIdx(failIdx), .sdClk(sdClk), .cardOe(cardOe),
    .cardBit(cardBit), .lastFrame(lastFrame), .prevFrame(prevFrame),
    .frames(frames));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ****************************************************************
  // bus, compare and helper tasks
  // ****************************************************************
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    ahb(1'b0, a, 32'h0, r);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkf(input logic [47:0] g, input sdhts_pkg::sdhts_cmd_s e);
    checks_done++;
    if ({g[47:8], g[0]} !== {2'b01, e, 1'b1}) begin
      fails++;
      $display("[ERR] %0t frame %h expected %h", $time, g, e);
    end
  endtask
  // stops at idle or at the start of a data phase
  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h1;
    for (int n = 0; n < 3000 && s[0] && !s[1]; n++) rd(A_STAT, s);
    // a sequencer that never settles is a mismatch, not a silent pass
    if (s[0] && !s[1]) begin
      fails++;
      test_done;
    end
  endtask
  task automatic cmd(input logic [31:0] c);
    clkEn <= 1'b1;
    wr(A_CMD, c);
    wait_idle;
  endtask
  task automatic pulse;
    blockDone <= 1'b1;
    @(posedge mclk);
    blockDone <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [31:0] r;
    rd(A_BLK, r);
    chk(r, 32'h0);
    wr(A_BLK, 32'h0000_FFFF);
    rd(A_BLK, r);
    chk(r, 32'h0000_FFFF);
    wr(A_ARG, 32'hA5C3_0F96);
    rd(A_ARG, r);
    chk(r, 32'hA5C3_0F96);
    wr(A_MODE, 32'hFFFF_FFFF);
    rd(A_MODE, r);
    chk(r, 32'h0000_003F);
    chk({31'h0, xferRead}, 32'h1);
    rd(8'h7C, r);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("t_regs finished");
  endtask
  task automatic t_single;
    logic [31:0] r;
    wr(A_BLK, 32'h5);
    wr(A_ARG, 32'h1234_5678);
    wr(A_MODE, 32'h10);
    cmd(32'h1120);
    chkf(lastFrame, '{6'h11, 32'h1234_5678});
    chk({31'h0, xferActive}, 32'h1);
    chk({31'h0, xferRead}, 32'h1);
    pulse;
    chk({31'h0, xferActive}, 32'h0);
    rd(A_BLK, r);
    chk(r, 32'h5);
    repeat (100) @(posedge mclk);
    chk({31'h0, cmdOe}, 32'h0);
    clkEn <= 1'b0;
    $display("t_single finished");
  endtask
  task automatic t_auto12;
    logic [31:0] r;
    failIdx <= sdhts_pkg::CMD12_IDX;
    wr(A_BLK, 32'h2);
    wr(A_MODE, 32'h26);
    cmd(32'h1920);
    chk({31'h0, xferRead}, 32'h0);
    pulse;
    rd(A_BLK, r);
    chk(r, 32'h1);
    chk({31'h0, xferActive}, 32'h1);
    pulse;
    for (int n = 0; n < 400 && !cmdOe; n++) @(posedge mclk);
    chk({31'h0, xferActive}, 32'h0);
    wait_idle;
    chkf(lastFrame, '{sdhts_pkg::CMD12_IDX, 32'h0});
    pulse;
    rd(A_BLK, r);
    chk(r, 32'h0);
    rd(A_AERR, r);
    chk(r, 32'h1);
    wr(A_AERR, 32'h1);
    rd(A_AERR, r);
    chk(r, 32'h0);
    failIdx <= 6'h3F;
    clkEn <= 1'b0;
    $display("t_auto12 finished");
  endtask
  task automatic t_auto23;
    logic [31:0] r;
    int f0;
    wr(A_SDMA, 32'h0000_0001);
    wr(A_BLK, 32'h1);
    wr(A_ARG, 32'h0000_4C00);
    wr(A_MODE, 32'h2B);
    f0 = frames;
    cmd(32'h1220);
    chk(32'(frames - f0), 32'h2);
    chkf(prevFrame, '{sdhts_pkg::CMD23_IDX, 32'h1});
    chkf(lastFrame, '{6'h12, 32'h4C00});
    chk({31'h0, xferDma}, 32'h1);
    pulse;
    chk({31'h0, xferActive}, 32'h0);
    failIdx <= sdhts_pkg::CMD23_IDX;
    wr(A_BLK, 32'h1);
    f0 = frames;
    cmd(32'h1220);
    chk(32'(frames - f0), 32'h1);
    chk({31'h0, xferActive}, 32'h0);
    rd(A_AERR, r);
    chk(r, 32'h2);
    failIdx <= 6'h3F;
    clkEn <= 1'b0;
    $display("t_auto23 finished");
  endtask
  task automatic t_suspend;
    logic [31:0] r;
    logic [31:0] m;
    wr(A_BLK, 32'h3);
    wr(A_MODE, 32'h30);
    cmd(32'h1220);
    repeat (4) pulse;
    rd(A_BLK, r);
    chk(r, 32'h3);
    chk({31'h0, xferActive}, 32'h1);
    cmd(32'h3400);
    chk({31'h0, xferActive}, 32'h0);
    wr(A_MODE, 32'h32);
    cmd(32'h1220);
    pulse;
    cmd(32'h3400);
    rd(A_BLK, r);
    chk(r, 32'h2);
    rd(A_MODE, m);
    wr(A_BLK, r);
    wr(A_MODE, m);
    cmd(32'h1220);
    pulse;
    pulse;
    rd(A_BLK, r);
    chk(r, 32'h0);
    chk({31'h0, xferActive}, 32'h0);
    cmd(32'h1220);
    chk({31'h0, xferActive}, 32'h0);
    clkEn <= 1'b0;
    $display("t_suspend finished");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a full run needs well under a millisecond
  initial begin
    #2000000;
    fails++;
    test_done;
  end
  initial begin
    srst = 1'b1;
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = sdhts_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    blockDone = 1'b0;
    clkEn = 1'b0;
    failIdx = 6'h3F;
    fails = 0;
    checks_done = 0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_regs;
    t_single;
    t_auto12;
    t_auto23;
    t_suspend;
    test_done;
  end
endmodule // tb
bind sdhts_transfer_setup sdhts_checker u_sdhts_checker (.mclk(mclk),
  .srst(srst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .cmdOut(cmdOut), .cmdOe(cmdOe),
  .blockDone(blockDone), .xferActive(xferActive));
